// file: ovr_sequencer.sv
// Conversion routine sequencer with configuration override and its registers.
// Assumes step fault and sleep inputs come from logic on ref_clk.
module ovr_sequencer #(
   parameter int STEP_BASE_CYC = ovr_pkg::STEP_BASE_CYC,
   parameter int TCYC_UNIT_CYC = ovr_pkg::TCYC_UNIT_CYC
) (
   // Clock and reset
   input  wire logic                               ref_clk,
   input  wire logic                               rstn,
   // Register port
   input  wire ovr_pkg::bus_req_s                  bus_req,
   output logic [ovr_pkg::DATA_W-1:0]              rd_data,
   // Measurement side
   input  wire logic [ovr_pkg::NSTEPS-1:0]         step_fault,
   input  wire logic                               sleep_mode,
   output logic [ovr_pkg::NSTEPS-1:0]              step_active,
   output logic [ovr_pkg::FILT_W-1:0]              filt_sel,
   // Status
   output logic                                    routine_active,
   output logic                                    override_sticky_flag
);

   localparam int SW = $clog2(ovr_pkg::NSTEPS);
   localparam logic [SW-1:0] LAST_STEP = SW'(ovr_pkg::NSTEPS - 1);

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef struct packed {
      ovr_pkg::seq_state_e                st;
      logic [SW-1:0]                      step;
      logic                               mode_od;
      logic [ovr_pkg::FILT_W-1:0]         filt;
      logic                               forced;
      logic                               run_fault;
      logic                               od_clean;
      logic                               od_fault;
      logic                               flag;
      logic                               active;
      logic                               cyc_en;
      logic [ovr_pkg::FILT_W-1:0]         filt_od;
      logic [ovr_pkg::FILT_W-1:0]         filt_cyc;
      logic [ovr_pkg::FILT_W-1:0]         filt_slp;
      logic [ovr_pkg::NSTEPS-1:0]         step_en;
      logic [ovr_pkg::DATA_W-1:0]         period;
      logic [ovr_pkg::TCYC_W-1:0]         tcyc;
      logic [ovr_pkg::NSTEPS-1:0]         diag;
      logic [ovr_pkg::NSTEPS-1:0]         clean;
      logic [1:0]                         cyc_cnt;
      logic [ovr_pkg::DATA_W-1:0]         rdata;
      logic                               tmr_go;
      logic [ovr_pkg::NSTEPS-1:0]         step_act;
   } seq_s;

   seq_s q;
   seq_s d;
   logic tmr_done;
   logic cyc_tick;
   logic wr_ctrl;
   logic rd_ctrl;
   logic rd_diag;
   logic launch;
   logic fault_set;
   logic exec_step;

   // ------------------------------------------------------------------
   // Timers
   // ------------------------------------------------------------------
   ovr_step_timer #(.BASE_CYC(STEP_BASE_CYC)) u_step_timer (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .start   (q.tmr_go),
      .filt    (q.filt),
      .done    (tmr_done)
   );

   ovr_cycle_timer #(.UNIT_CYC(TCYC_UNIT_CYC)) u_cycle_timer (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .en      (q.cyc_en),
      .period  (q.tcyc),
      .tick    (cyc_tick)
   );

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      d = q;
      d.tmr_go = 1'b0;
      d.rdata  = '0;
      wr_ctrl  = bus_req.wr && (bus_req.addr == ovr_pkg::ADDR_CTRL);
      rd_ctrl  = bus_req.rd && (bus_req.addr == ovr_pkg::ADDR_CTRL);
      rd_diag  = bus_req.rd && (bus_req.addr == ovr_pkg::ADDR_DIAG);
      launch   = wr_ctrl && bus_req.wdata[ovr_pkg::LAUNCH_BIT];
      fault_set = (q.st == ovr_pkg::ST_WAIT) && tmr_done && step_fault[q.step];
      // Step 0 is mandatory; forced steps ignore enable and periodicity
      exec_step = (q.step == '0) || q.forced ||
                  (q.mode_od ? q.step_en[q.step]
                             : ovr_pkg::step_due(q.period[q.step*ovr_pkg::PER_W +: ovr_pkg::PER_W],
                                                 q.cyc_cnt));

      // Register writes; host is expected to keep off these during override
      if (wr_ctrl) begin
         d.cyc_en   = bus_req.wdata[ovr_pkg::CYC_EN_BIT];
         d.filt_od  = bus_req.wdata[ovr_pkg::FILT_OD_LSB +: ovr_pkg::FILT_W];
         d.filt_cyc = bus_req.wdata[ovr_pkg::FILT_CYC_LSB +: ovr_pkg::FILT_W];
         d.filt_slp = bus_req.wdata[ovr_pkg::FILT_SLP_LSB +: ovr_pkg::FILT_W];
      end
      if (bus_req.wr && bus_req.addr == ovr_pkg::ADDR_STEP_EN) begin
         d.step_en = bus_req.wdata[ovr_pkg::NSTEPS-1:0];
      end
      if (bus_req.wr && bus_req.addr == ovr_pkg::ADDR_PERIOD) begin
         d.period = bus_req.wdata;
      end
      if (bus_req.wr && bus_req.addr == ovr_pkg::ADDR_TCYCLE) begin
         d.tcyc = bus_req.wdata[ovr_pkg::TCYC_W-1:0];
      end

      // Reads; the status bits let the host poll the routine
      if (rd_ctrl) begin
         d.rdata[ovr_pkg::CYC_EN_BIT] = q.cyc_en;
         d.rdata[ovr_pkg::FILT_OD_LSB +: ovr_pkg::FILT_W]  = q.filt_od;
         d.rdata[ovr_pkg::FILT_CYC_LSB +: ovr_pkg::FILT_W] = q.filt_cyc;
         d.rdata[ovr_pkg::FILT_SLP_LSB +: ovr_pkg::FILT_W] = q.filt_slp;
         d.rdata[ovr_pkg::FLAG_BIT]     = q.flag;
         d.rdata[ovr_pkg::ACTIVE_BIT]   = q.active;
         d.rdata[ovr_pkg::OVR_RUN_BIT]  = q.forced;
         d.rdata[ovr_pkg::OD_FAULT_BIT] = q.od_fault;
         if (q.od_clean) begin
            d.flag = 1'b0;
         end
      end else if (bus_req.rd) begin
         case (bus_req.addr)
            ovr_pkg::ADDR_STEP_EN: d.rdata[ovr_pkg::NSTEPS-1:0] = q.step_en;
            ovr_pkg::ADDR_PERIOD:  d.rdata = q.period;
            ovr_pkg::ADDR_TCYCLE:  d.rdata[ovr_pkg::TCYC_W-1:0] = q.tcyc;
            ovr_pkg::ADDR_DIAG:    d.rdata[ovr_pkg::NSTEPS-1:0] = q.diag;
            default:               d.rdata = '0;
         endcase
      end
      // A latch only clears once a later run converted that step cleanly
      if (rd_diag) begin
         d.diag = q.diag & ~q.clean;
      end

      // Periodicity count runs on every tick, also while the flag masks cyclic starts
      if (cyc_tick) begin
         d.cyc_cnt = q.cyc_cnt + 2'h1;
      end

      unique case (q.st)
         ovr_pkg::ST_IDLE: begin
            // On-demand wins over a cyclic tick in the same cycle
            if (launch) begin
               d.st        = ovr_pkg::ST_PICK;
               d.mode_od   = 1'b1;
               d.filt      = bus_req.wdata[ovr_pkg::FILT_OD_LSB +: ovr_pkg::FILT_W];
               d.od_clean  = 1'b0;
            end else if (cyc_tick && q.cyc_en && !q.flag) begin
               d.st        = ovr_pkg::ST_PICK;
               d.mode_od   = 1'b0;
               d.filt      = sleep_mode ? q.filt_slp : q.filt_cyc;
            end
            if (d.st == ovr_pkg::ST_PICK) begin
               d.step      = '0;
               d.forced    = 1'b0;
               d.run_fault = 1'b0;
               d.active    = 1'b1;
            end
         end
         ovr_pkg::ST_PICK: begin
            if (exec_step) begin
               d.tmr_go   = 1'b1;
               d.step_act = '0;
               d.step_act[q.step] = 1'b1;
               d.st       = ovr_pkg::ST_WAIT;
            end else if (q.step == LAST_STEP) begin
               d.st = ovr_pkg::ST_FINISH;
            end else begin
               d.step = q.step + SW'(1);
            end
         end
         ovr_pkg::ST_WAIT: begin
            if (tmr_done) begin
               d.step_act = '0;
               // Written after the latch clear above, so a new fault wins over a read
               if (step_fault[q.step]) begin
                  d.forced    = 1'b1;
                  d.run_fault = 1'b1;
                  d.diag[q.step]  = 1'b1;
                  d.clean[q.step] = 1'b0;
                  d.flag      = 1'b1;
               end else begin
                  d.clean[q.step] = 1'b1;
               end
               if (q.step == LAST_STEP) begin
                  d.st = ovr_pkg::ST_FINISH;
               end else begin
                  d.step = q.step + SW'(1);
                  d.st   = ovr_pkg::ST_PICK;
               end
            end
         end
         ovr_pkg::ST_FINISH: begin
            d.active = 1'b0;
            d.forced = 1'b0;
            // Outcome of an on-demand run decides whether a CTRL read may drop the flag
            if (q.mode_od) begin
               d.od_clean = !q.run_fault;
               d.od_fault = q.run_fault;
            end
            d.st = ovr_pkg::ST_IDLE;
         end
         default: begin
            d.st     = ovr_pkg::ST_IDLE;
            d.active = 1'b0;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         q          <= '0;
         q.st       <= ovr_pkg::ST_IDLE;
         q.filt_od  <= ovr_pkg::FILT_RST;
         q.filt_cyc <= ovr_pkg::FILT_RST;
         q.filt_slp <= ovr_pkg::FILT_RST;
         q.step_en  <= ovr_pkg::STEP_EN_RST;
         q.period   <= ovr_pkg::PERIOD_RST;
         q.tcyc     <= ovr_pkg::TCYCLE_RST;
      end else begin
         q <= d;
      end
   end

   assign rd_data              = q.rdata;
   assign step_active          = q.step_act;
   assign filt_sel             = q.filt;
   assign routine_active       = q.active;
   assign override_sticky_flag = q.flag;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   flag_on_fault_a: assert property (fault_set |=> q.flag && q.forced)
      else $error("fault did not set override flag");
   forced_step_a: assert property (q.st == ovr_pkg::ST_PICK && q.forced
                                   |=> q.st == ovr_pkg::ST_WAIT)
      else $error("forced step was skipped");
   diag_catch_a: assert property (fault_set |=> q.diag[$past(q.step)])
      else $error("fault not latched in diagnostics");
   diag_hold_a: assert property (rd_diag && (q.diag & ~q.clean) != '0
                                 |=> (q.diag & $past(q.diag & ~q.clean)) == $past(q.diag & ~q.clean))
      else $error("unvalidated fault latch cleared");
   keep_flag_a: assert property (rd_ctrl && q.flag && !q.od_clean
                                 |=> q.flag)
      else $error("flag cleared without clean run");
   clear_flag_a: assert property (rd_ctrl && q.flag && q.od_clean && !fault_set
                                  |=> !q.flag)
      else $error("flag not cleared after clean run");
   cyclic_mask_a: assert property (q.st == ovr_pkg::ST_IDLE && q.flag && !launch
                                   |=> q.st == ovr_pkg::ST_IDLE)
      else $error("routine left idle under override");
   filter_hold_a: assert property (q.active && $past(q.active) |-> $stable(q.filt))
      else $error("filter changed during routine");
   step_order_a: assert property (q.st == ovr_pkg::ST_WAIT && tmr_done
                                  && q.step != LAST_STEP |=> q.step == $past(q.step) + SW'(1))
      else $error("step order broken");
   active_flag_a: assert property (q.active == (q.st != ovr_pkg::ST_IDLE))
      else $error("active flag out of step with routine");
   step_time_a: assert property ($rose(q.st == ovr_pkg::ST_WAIT) && q.filt == '0
                                 |-> ##[1:1000] tmr_done)
      else $error("step did not finish in time");

   // ------------------------------------------------------------------
   // Checks on steps, status and run start
   // ------------------------------------------------------------------
   // Steps are converted one at a time and never while idle
   step_onehot_a: assert property ($onehot0(q.step_act))
      else $error("more than one step active");
   idle_quiet_a: assert property (q.st == ovr_pkg::ST_IDLE |-> q.step_act == '0)
      else $error("step active while routine idle");
   flag_sticky_a: assert property (q.flag && !rd_ctrl |=> q.flag)
      else $error("override flag dropped without a read");
   od_result_a: assert property (q.st == ovr_pkg::ST_FINISH && q.mode_od
                                 |=> q.od_clean == !$past(q.run_fault))
      else $error("on-demand result not recorded");
   // A tick while idle, enabled and unmasked starts a cyclic run
   cyclic_start_a: assert property (q.st == ovr_pkg::ST_IDLE && q.cyc_en
                                    && cyc_tick && !q.flag && !launch
                                    |=> q.active && !q.mode_od)
      else $error("cyclic run did not start");
   launch_drop_a: assert property (launch && q.st == ovr_pkg::ST_WAIT
                                   |=> $stable(q.filt) && q.active)
      else $error("launch disturbed a running routine");
   od_filter_a: assert property (launch && q.st == ovr_pkg::ST_IDLE
                                 |=> q.mode_od && q.filt == q.filt_od)
      else $error("on-demand run took wrong filter");
   rdata_idle_a: assert property (!bus_req.rd |=> q.rdata == '0)
      else $error("read data not cleared");

endmodule : ovr_sequencer

// file: ovr_pkg.sv
// Constants, register map, state codes and bus carrier for the conversion
// override sequencer. Assumes one 25 MHz clock and a same-clock register master.
// Function
// - Any fault during a routine step starts override, on-demand or cyclic, unasked.
// - After a fault, every later step runs, even if disabled or not due.
// - Each fault seen during forced steps is caught in its diagnostic latch.
// - The sticky override flag is set when a fault asserts in a running routine.
// - A read clears the flag only if the last on-demand run was fault-free.
// - Measurement fault latches clear only after a new clean conversion of that step.
// - While the flag is set, cyclic enable is masked; no cyclic restart.
// - After override's active phase ends, the routine stays idle awaiting the host.
// - Control register read clears the flag after a clean on-demand run, else keeps it.
// - Forced steps keep the filter setting of the interrupted mode.
// - Routine status is readable so the host can poll override activity.
// - Steps always run in one fixed order, detection before validation checks.
// - Routine-active flag is high during the active phase only.
package ovr_pkg;

   // ------------------------------------------------------------------
   // Sizes
   // ------------------------------------------------------------------
   localparam int NSTEPS = 8;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   localparam int FILT_W = 3;
   localparam int PER_W  = 2;
   localparam int TCYC_W = 8;
   localparam int CNT_W  = 20;

   // ------------------------------------------------------------------
   // Register map and fields
   // ------------------------------------------------------------------
   localparam logic [ADDR_W-1:0] ADDR_CTRL    = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_STEP_EN = 4'h1;
   localparam logic [ADDR_W-1:0] ADDR_PERIOD  = 4'h2;
   localparam logic [ADDR_W-1:0] ADDR_TCYCLE  = 4'h3;
   localparam logic [ADDR_W-1:0] ADDR_DIAG    = 4'h4;

   localparam int CYC_EN_BIT   = 0;
   localparam int LAUNCH_BIT   = 1;
   localparam int FILT_OD_LSB  = 2;
   localparam int FILT_CYC_LSB = 5;
   localparam int FILT_SLP_LSB = 8;
   localparam int FLAG_BIT     = 11;
   localparam int ACTIVE_BIT   = 12;
   localparam int OVR_RUN_BIT  = 13;
   localparam int OD_FAULT_BIT = 14;

   localparam logic [FILT_W-1:0] FILT_RST    = 3'h0;
   localparam logic [NSTEPS-1:0] STEP_EN_RST = 8'hFF;
   localparam logic [DATA_W-1:0] PERIOD_RST  = 16'h5555;
   localparam logic [TCYC_W-1:0] TCYCLE_RST  = 8'h0A;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 40;
   localparam int STEP_BASE_NS  = 10000;
   localparam int STEP_BASE_CYC = (STEP_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TCYC_UNIT_NS  = 100000;
   localparam int TCYC_UNIT_CYC = TCYC_UNIT_NS / CLK_PERIOD_NS;

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } bus_req_s;

   typedef enum logic [3:0] {
      ST_IDLE   = 4'b0001,
      ST_PICK   = 4'b0010,
      ST_WAIT   = 4'b0100,
      ST_FINISH = 4'b1000
   } seq_state_e;

   // Periodicity code: 0 never, 1 every cycle, 2 every 2nd, 3 every 4th
   function automatic logic step_due(input logic [PER_W-1:0] per, input logic [1:0] cnt);
      logic due;
      due = 1'b0;
      case (per)
         2'h1:    due = 1'b1;
         2'h2:    due = (cnt[0] == 1'b0);
         2'h3:    due = (cnt == 2'h0);
         default: due = 1'b0;
      endcase
      return due;
   endfunction : step_due

endpackage : ovr_pkg

// file: ovr_step_timer.sv
// Step duration timer: one step lasts the base time times two to the power of the filter code.
// Assumes a one-cycle start pulse from the sequencer on the same clock.
module ovr_step_timer #(
   parameter int BASE_CYC = ovr_pkg::STEP_BASE_CYC
) (
   // Clock and reset
   input  wire logic                       ref_clk,
   input  wire logic                       rstn,
   // Control
   input  wire logic                       start,
   input  wire logic [ovr_pkg::FILT_W-1:0] filt,
   output logic                            done
);

   typedef struct packed {
      logic [ovr_pkg::CNT_W-1:0] cnt;
      logic                      busy;
      logic                      done;
   } tmr_s;

   tmr_s q;
   tmr_s d;
   localparam logic [ovr_pkg::CNT_W-1:0] BASE = ovr_pkg::CNT_W'(BASE_CYC);

   always_comb begin
      d = q;
      d.done = 1'b0;
      if (start) begin
         d.cnt  = (BASE << filt) - ovr_pkg::CNT_W'(1);
         d.busy = 1'b1;
      end else if (q.busy) begin
         if (q.cnt == '0) begin
            d.busy = 1'b0;
            d.done = 1'b1;
         end else begin
            d.cnt = q.cnt - ovr_pkg::CNT_W'(1);
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign done = q.done;

endmodule : ovr_step_timer

// file: ovr_cycle_timer.sv
// Cycle period timer: a unit divider and a period counter give one tick per cycle.
// Assumes the period register is stable while the timer runs.
module ovr_cycle_timer #(
   parameter int UNIT_CYC = ovr_pkg::TCYC_UNIT_CYC
) (
   // Clock and reset
   input  wire logic                       ref_clk,
   input  wire logic                       rstn,
   // Control
   input  wire logic                       en,
   input  wire logic [ovr_pkg::TCYC_W-1:0] period,
   output logic                            tick
);

   typedef struct packed {
      logic [ovr_pkg::CNT_W-1:0]  div;
      logic [ovr_pkg::TCYC_W-1:0] units;
      logic                       tick;
   } cyc_s;

   cyc_s q;
   cyc_s d;
   localparam logic [ovr_pkg::CNT_W-1:0] UNIT_LAST = ovr_pkg::CNT_W'(UNIT_CYC - 1);

   always_comb begin
      d = q;
      d.tick = 1'b0;
      if (!en) begin
         d.div   = '0;
         d.units = '0;
      end else if (q.div == UNIT_LAST) begin
         d.div = '0;
         if (q.units + ovr_pkg::TCYC_W'(1) >= period) begin
            d.units = '0;
            d.tick  = 1'b1;
         end else begin
            d.units = q.units + ovr_pkg::TCYC_W'(1);
         end
      end else begin
         d.div = q.div + ovr_pkg::CNT_W'(1);
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign tick = q.tick;

endmodule : ovr_cycle_timer

// file: host_model.sv
// Host controller model: issues register reads and writes to the sequencer.
// Assumes one shared clock; read data stands in the cycle after the strobe.
module host_model (
   // Clock
   input  wire logic                       ref_clk,
   // Register port
   output ovr_pkg::bus_req_s               bus_req,
   input  wire logic [ovr_pkg::DATA_W-1:0] rd_data
);
   timeunit 1ns;
   timeprecision 1ns;

   initial bus_req = '0;

   // Released lines carry the inverse, so a stale address never looks valid
   task automatic xfer(input logic w, input logic [3:0] a, input logic [15:0] d,
                       output logic [15:0] q);
      @(posedge ref_clk);
      bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
      @(posedge ref_clk);
      bus_req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
      #1 q = rd_data;
   endtask : xfer

   task automatic write_reg(input logic [3:0] a, input logic [15:0] d);
      logic [15:0] q;
      xfer(1'b1, a, d, q);
   endtask : write_reg

   // Diagnostic and control reads for validation
   task automatic read_reg(input logic [3:0] a, output logic [15:0] q);
      xfer(1'b0, a, 16'h0000, q);
   endtask : read_reg

   // Launch with cyclic enable cleared in the same write
   task automatic launch_od(input logic [2:0] fo);
      write_reg(ovr_pkg::ADDR_CTRL, {11'h000, fo, 2'h2});
   endtask : launch_od

   // Start or resume cyclic runs
   task automatic start_cyc(input logic [2:0] fc, input logic [2:0] fs);
      write_reg(ovr_pkg::ADDR_CTRL, {5'h00, fs, fc, 3'h0, 2'h1});
   endtask : start_cyc
endmodule : host_model

// file: conversion_override_control_tb.sv
// Self-checking bench for the override sequencer.
// Assumes shortened step and cycle units; host model drives the register port.
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin mismatches++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module conversion_override_control_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic              ref_clk = 1'b0;
   logic              rstn = 1'b0;
   ovr_pkg::bus_req_s bus_req;
   logic [15:0]       rd_data, q;
   logic [7:0]        step_fault = '0, step_active, seen = '0, last = '0, en, fm;
   logic              sleep_mode = 1'b0, routine_active, override_sticky_flag;
   logic              order_err = 1'b0, act_d = 1'b0, clr = 1'b0;
   logic [2:0]        filt_sel, fseen = '0, fo, fc, fs;
   int                mismatches = 0, checks = 0, seed = 76, runs = 0, k, r0;
   logic [15:0]       rst_img [6] = '{16'h0000, 16'h00FF, 16'h5555, 16'h000A, 16'h0, 16'h0};

   always #20 ref_clk = ~ref_clk;

   ovr_sequencer #(.STEP_BASE_CYC(4), .TCYC_UNIT_CYC(8)) i_ovr_sequencer (
      .ref_clk(ref_clk), .rstn(rstn), .bus_req(bus_req), .rd_data(rd_data),
      .step_fault(step_fault), .sleep_mode(sleep_mode), .step_active(step_active),
      .filt_sel(filt_sel), .routine_active(routine_active),
      .override_sticky_flag(override_sticky_flag));
   host_model i_host_model (.ref_clk(ref_clk), .bus_req(bus_req), .rd_data(rd_data));

   always @(posedge ref_clk) begin
      act_d <= routine_active;
      if (routine_active && !act_d) runs <= runs + 1;
      // Cleared on request so that only this process writes seen and last
      if (clr) begin
         seen <= '0;
         last <= '0;
      end else if (step_active != '0) begin
         seen <= seen | step_active;
         fseen <= filt_sel;
         if (step_active < last) order_err <= 1'b1;
         last <= step_active;
      end
   end

   // Step 0 always runs; a fault forces every later step
   function automatic logic [7:0] exp_run(input logic [7:0] e, input logic [7:0] f);
      logic forced;
      forced = 1'b0;
      for (int i = 0; i < 8; i++) begin
         if (e[i] || i == 0 || forced) begin
            e[i] = 1'b1;
            forced = forced | f[i];
         end
      end
      return e;
   endfunction : exp_run

   task automatic wait_end();
      int n;
      n = 0;
      while (!routine_active && n < 60) begin @(posedge ref_clk); #1 n++; end
      `CHK(routine_active, 1'b1)
      // Eight steps at filter code 7 take a little over 4,100 cycles
      while (routine_active && n < 5000) begin @(posedge ref_clk); #1 n++; end
      `CHK(routine_active, 1'b0)
   endtask : wait_end

   task automatic run_od(input logic [7:0] e, input logic [7:0] f, input logic [2:0] fo);
      logic pf;
      pf = override_sticky_flag;
      @(posedge ref_clk);
      step_fault <= f;
      clr <= 1'b1;
      i_host_model.write_reg(ovr_pkg::ADDR_STEP_EN, {8'h00, e});
      clr <= 1'b0;
      i_host_model.launch_od(fo);
      i_host_model.read_reg(ovr_pkg::ADDR_CTRL, q);
      `CHK(q[12], 1'b1)
      wait_end();
      `CHK(seen, exp_run(e, f))
      `CHK(fseen, fo)
      `CHK(override_sticky_flag, pf | (|(exp_run(e, f) & f)))
   endtask : run_od

   task automatic test_done();
      $display("checks=%0d mismatches=%0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done

   initial begin
      // The full set of runs needs about 30,000 cycles at the slowest filters
      #(40 * 60000);
      mismatches++;
      test_done();
   end

   initial begin
      repeat (2) @(posedge ref_clk);
      rstn <= 1'b1;
      for (int a = 0; a < 6; a++) begin
         i_host_model.read_reg(a[3:0], q);
         `CHK(q, rst_img[a])
      end
      $display("test reset images done");
      repeat (3) begin
         en = 8'($random(seed));
         fo = 3'($random(seed));
         run_od(en, 8'h00, fo);
      end
      $display("test clean runs done");
      k = 1 + int'($unsigned($random(seed)) % 6);
      fm = (8'h01 << k) | 8'h80;
      // Step k must be enabled to fault; the disabled steps after it are forced
      run_od(8'h01 | fm, fm, fo);
      i_host_model.read_reg(ovr_pkg::ADDR_CTRL, q);
      @(posedge ref_clk);
      #1 `CHK(override_sticky_flag, 1'b1)
      run_od(8'h01, 8'h00, fo);
      i_host_model.read_reg(ovr_pkg::ADDR_CTRL, q);
      @(posedge ref_clk);
      #1 `CHK(override_sticky_flag, 1'b0)
      i_host_model.read_reg(ovr_pkg::ADDR_DIAG, q);
      `CHK(q[7:0], fm)
      i_host_model.read_reg(ovr_pkg::ADDR_DIAG, q);
      `CHK(q[7:0], fm)
      run_od(8'hFF, 8'h00, fo);
      i_host_model.read_reg(ovr_pkg::ADDR_DIAG, q);
      i_host_model.read_reg(ovr_pkg::ADDR_DIAG, q);
      `CHK(q[7:0], 8'h00)
      $display("test on-demand override done");
      fc = 3'($random(seed));
      fs = 3'($random(seed));
      @(posedge ref_clk);
      sleep_mode <= 1'($random(seed));
      step_fault <= 8'h01;
      clr <= 1'b1;
      i_host_model.write_reg(ovr_pkg::ADDR_PERIOD, 16'h0001);
      clr <= 1'b0;
      i_host_model.write_reg(ovr_pkg::ADDR_TCYCLE, 16'h0001);
      r0 = runs;
      i_host_model.start_cyc(fc, fs);
      wait_end();
      `CHK(seen, 8'hFF)
      `CHK(fseen, sleep_mode ? fs : fc)
      `CHK(override_sticky_flag, 1'b1)
      repeat (100) @(posedge ref_clk);
      #1 `CHK(runs, r0 + 1)
      `CHK(order_err, 1'b0)
      // Bench writes nothing while the override runs
      i_host_model.read_reg(ovr_pkg::ADDR_DIAG, q);
      `CHK(q[7:0], 8'h01)
      run_od(8'hFF, 8'h00, fo);
      i_host_model.read_reg(ovr_pkg::ADDR_CTRL, q);
      @(posedge ref_clk);
      #1 `CHK(override_sticky_flag, 1'b0)
      clr <= 1'b1;
      @(posedge ref_clk);
      clr <= 1'b0;
      i_host_model.start_cyc(fc, fs);
      wait_end();
      `CHK(seen, 8'h01)
      $display("test cyclic override done");
      test_done();
   end
endmodule : conversion_override_control_tb
